// File: common/gpt_pkg.sv
package gpt_pkg;

  localparam int          GPT_CNT_W   = 16;
  localparam int          GPT_PSC_W   = 16;
  localparam int          GPT_CLK_HZ  = 200_000_000;
  localparam int          GPT_LSE_HZ  = 32_768;
  localparam logic [15:0] GPT_CNT_RST = 16'h0000;

  // Counter clock source select
  localparam logic [1:0] GPT_CKS_INT  = 2'h0;
  localparam logic [1:0] GPT_CKS_LSE  = 2'h1;
  localparam logic [1:0] GPT_CKS_TRIG = 2'h2;
  localparam logic [1:0] GPT_CKS_ENC  = 2'h3;

  // Channel modes
  localparam logic [1:0] GPT_CHM_CAPTURE = 2'h0;
  localparam logic [1:0] GPT_CHM_TOGGLE  = 2'h1;
  localparam logic [1:0] GPT_CHM_PWM     = 2'h2;
  localparam logic [1:0] GPT_CHM_PULSE   = 2'h3;

  // Reaction to the inter-timer trigger input
  localparam logic [1:0] GPT_SLV_OFF   = 2'h0;
  localparam logic [1:0] GPT_SLV_RESET = 2'h1;
  localparam logic [1:0] GPT_SLV_GATED = 2'h2;
  localparam logic [1:0] GPT_SLV_START = 2'h3;

  // Trigger output select
  localparam logic GPT_TRO_UPDATE = 1'b0;
  localparam logic GPT_TRO_CC0    = 1'b1;

  // Compare hit: only on the cycle after the counter moved
  function automatic logic gpt_hit(input logic chg, input logic [15:0] cnt,
                                   input logic [15:0] ccr);
    return chg && (cnt == ccr);
  endfunction

  // Quadrature direction: up when new A differs from previous B
  function automatic logic gpt_quad_up(input logic a_now, input logic b_prev);
    return a_now ^ b_prev;
  endfunction

endpackage

// File: rtl/gpt_sync.sv
`timescale 1ns/1ps
module gpt_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] prev_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] edge_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Two-stage synchroniser; third stage feeds edge detection and prev_o
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edges come from settled stages only
  assign q_o    = s2_r;
  assign prev_o = s3_r;
  assign rise_o = s2_r & ~s3_r;
  assign edge_o = s2_r ^ s3_r;

endmodule // gpt_sync

// File: rtl/gpt_timer.sv
`timescale 1ns/1ps
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int NUM_CH     = 4,
  parameter bit ALLOW_DOWN = 1'b1,
  parameter bit HAS_DMA    = 1'b1
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        cnt_en_i,
  input  wire logic                        dir_down_i,
  input  wire logic                        center_i,
  input  wire logic                        one_pulse_i,
  input  wire logic [1:0]                  clk_sel_i,
  input  wire logic [GPT_PSC_W-1:0]        psc_i,
  input  wire logic [GPT_CNT_W-1:0]        reload_i,
  input  wire logic                        dbg_halt_i,
  input  wire logic                        dbg_freeze_i,
  input  wire logic                        lse_clk_i,
  input  wire logic                        trig_in_i,
  input  wire logic [1:0]                  slave_mode_i,
  input  wire logic                        trig_out_sel_i,
  input  wire logic                        hall_mode_i,
  input  wire logic [2:0]                  hall_i,
  input  wire logic [NUM_CH-1:0]           cap_pin_i,
  input  wire logic [2*NUM_CH-1:0]         ch_mode_i,
  input  wire logic [GPT_CNT_W*NUM_CH-1:0] ccr_i,
  input  wire logic                        dma_en_i,
  input  wire logic                        dma_ack_i,
  output logic      [GPT_CNT_W-1:0]        cnt_o,
  output logic                             dir_down_o,
  output logic                             running_o,
  output logic                             update_o,
  output logic                             trig_out_o,
  output logic      [NUM_CH-1:0]           ch_out_o,
  output logic      [NUM_CH-1:0]           cc_evt_o,
  output logic      [GPT_CNT_W*NUM_CH-1:0] cap_val_o,
  output logic                             dma_req_o
);

  // Only the three documented variants are served
  if (!(NUM_CH == 1 || NUM_CH == 2 || NUM_CH == 4)) begin : g_bad_ch
    $error("gpt_timer: NUM_CH must be 1, 2 or 4");
  end
  if (NUM_CH == 1 && ALLOW_DOWN) begin : g_bad_dir
    $error("gpt_timer: single-channel variant counts up only");
  end

  localparam bit ENC_OK = (NUM_CH >= 2) && ALLOW_DOWN;

  logic                 lse_rise;
  logic [NUM_CH-1:0]    cap_q;
  logic [NUM_CH-1:0]    cap_prev;
  logic [NUM_CH-1:0]    cap_rise;
  logic [NUM_CH-1:0]    cap_edge;
  logic [2:0]           hall_edge;
  logic                 hall_chg;
  logic                 enc_ev;
  logic                 enc_up;
  logic [GPT_CNT_W-1:0] cnt_r,    cnt_nxt;
  logic [GPT_PSC_W-1:0] psc_r,    psc_nxt;
  logic                 down_r,   down_nxt;
  logic                 run_r,    run_nxt;
  logic                 en_d_r,   en_d_nxt;
  logic                 upd_r,    upd_nxt;
  logic                 chg_r,    chg_nxt;
  logic                 dma_r,    dma_nxt;
  logic                 tro_r,    tro_nxt;
  logic [NUM_CH-1:0]    cc_ev_r;

  // Low-speed clock is just another pin: synchronised, rising edge counts
  gpt_sync #(.W(1)) u_lse_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (lse_clk_i),
    .q_o    (),
    .prev_o (),
    .rise_o (lse_rise),
    .edge_o ()
  );

  gpt_sync #(.W(NUM_CH)) u_cap_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (cap_pin_i),
    .q_o    (cap_q),
    .prev_o (cap_prev),
    .rise_o (cap_rise),
    .edge_o (cap_edge)
  );

  gpt_sync #(.W(3)) u_hall_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (hall_i),
    .q_o    (),
    .prev_o (),
    .rise_o (),
    .edge_o (hall_edge)
  );

  // Any change on any of the up to three sensors marks a commutation
  assign hall_chg = (NUM_CH == 4) && hall_mode_i && (|hall_edge);

  // Encoder uses channel 0 and 1 pins as A and B, counting every edge
  if (ENC_OK) begin : g_enc
    assign enc_ev = cap_edge[0] | cap_edge[1];
    assign enc_up = gpt_quad_up(cap_q[0], cap_prev[1]);
  end else begin : g_noenc
    assign enc_ev = 1'b0;
    assign enc_up = 1'b1;
  end

  // Counter, prescaler and run control
  always_comb begin
    logic tick;
    logic step;
    logic dn;
    logic gate;
    logic frozen;
    tick     = 1'b0;
    step     = 1'b0;
    dn       = 1'b0;
    cnt_nxt  = cnt_r;
    psc_nxt  = psc_r;
    down_nxt = down_r;
    run_nxt  = run_r;
    en_d_nxt = cnt_en_i;
    upd_nxt  = 1'b0;
    chg_nxt  = 1'b0;
    frozen   = dbg_freeze_i && dbg_halt_i;
    gate     = (slave_mode_i != GPT_SLV_GATED) || trig_in_i;
    // Start on enable edge, or on a peer trigger in start mode
    if (slave_mode_i == GPT_SLV_START) begin
      if (cnt_en_i && trig_in_i) run_nxt = 1'b1;
    end else if (cnt_en_i && !en_d_r) begin
      run_nxt = 1'b1;
    end
    unique case (clk_sel_i)
      GPT_CKS_INT:  tick = 1'b1;
      GPT_CKS_LSE:  tick = lse_rise;
      GPT_CKS_TRIG: tick = trig_in_i;
      GPT_CKS_ENC:  tick = 1'b0;
    endcase
    // Direction: up-only variant ignores the direction controls
    if (!ALLOW_DOWN) dn = 1'b0;
    else if (clk_sel_i == GPT_CKS_ENC) dn = !enc_up;
    else if (center_i) dn = down_r;
    else dn = dir_down_i;
    if ((slave_mode_i == GPT_SLV_RESET && trig_in_i) || hall_chg) begin
      // External reset restarts the period and reports it
      cnt_nxt = dn ? reload_i : GPT_CNT_RST;
      psc_nxt = '0;
      upd_nxt = 1'b1;
      chg_nxt = 1'b1;
    end else if (run_r && !frozen && gate) begin
      if (clk_sel_i == GPT_CKS_ENC) begin
        step = enc_ev;
      end else if (tick) begin
        // Divide by psc_i + 1: step when the count reaches psc_i
        if (psc_r >= psc_i) begin
          psc_nxt = '0;
          step    = 1'b1;
        end else begin
          psc_nxt = psc_r + 16'h0001;
        end
      end
    end
    if (step) begin
      chg_nxt = 1'b1;
      if (ALLOW_DOWN && center_i && clk_sel_i != GPT_CKS_ENC) begin
        // Centre mode turns round at both ends, one update each
        if (!down_r) begin
          if (cnt_r >= reload_i) begin
            down_nxt = 1'b1;
            cnt_nxt  = (reload_i == GPT_CNT_RST) ? GPT_CNT_RST : reload_i - 16'h0001;
            upd_nxt  = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end else if (cnt_r == GPT_CNT_RST) begin
          down_nxt = 1'b0;
          cnt_nxt  = (reload_i == GPT_CNT_RST) ? GPT_CNT_RST : 16'h0001;
          upd_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else if (dn) begin
        down_nxt = 1'b1;
        if (cnt_r == GPT_CNT_RST) begin
          cnt_nxt = reload_i;
          upd_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else begin
        down_nxt = 1'b0;
        if (cnt_r >= reload_i) begin
          cnt_nxt = GPT_CNT_RST;
          upd_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
    end
    // One-pulse mode stops at the update; disabling always wins
    if (upd_nxt && one_pulse_i) run_nxt = 1'b0;
    if (!cnt_en_i) run_nxt = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= GPT_CNT_RST;
      psc_r  <= '0;
      down_r <= 1'b0;
      run_r  <= 1'b0;
      en_d_r <= 1'b0;
      upd_r  <= 1'b0;
      chg_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      psc_r  <= psc_nxt;
      down_r <= down_nxt;
      run_r  <= run_nxt;
      en_d_r <= en_d_nxt;
      upd_r  <= upd_nxt;
      chg_r  <= chg_nxt;
    end
  end

  // One block of state per channel; count set by the variant
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [GPT_CNT_W-1:0] ccr;
    logic [1:0]           mode;
    logic                 cap_ev;
    logic                 hit;
    logic [GPT_CNT_W-1:0] cap_r, cap_nxt;
    logic                 out_r, out_nxt;
    logic                 ev_nxt;

    assign ccr    = ccr_i[ch*GPT_CNT_W +: GPT_CNT_W];
    assign mode   = ch_mode_i[ch*2 +: 2];
    assign cap_ev = (ch == 0 && hall_mode_i) ? hall_chg : cap_rise[ch];
    assign hit    = gpt_hit(chg_r, cnt_r, ccr);

    // Capture latches the counter; outputs follow the compare value
    always_comb begin
      cap_nxt = cap_r;
      out_nxt = out_r;
      ev_nxt  = 1'b0;
      unique case (mode)
        GPT_CHM_CAPTURE: begin
          out_nxt = 1'b0;
          if (cap_ev) begin
            cap_nxt = cnt_r;
            ev_nxt  = 1'b1;
          end
        end
        GPT_CHM_TOGGLE: begin
          if (hit) out_nxt = !out_r;
          ev_nxt = hit;
        end
        GPT_CHM_PWM: begin
          out_nxt = (cnt_r < ccr);
          ev_nxt  = hit;
        end
        GPT_CHM_PULSE: begin
          // Delayed pulse; ends when one-pulse stops the counter
          out_nxt = run_r && (cnt_r >= ccr);
          ev_nxt  = hit;
        end
      endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cap_r       <= GPT_CNT_RST;
        out_r       <= 1'b0;
        cc_ev_r[ch] <= 1'b0;
      end else begin
        cap_r       <= cap_nxt;
        out_r       <= out_nxt;
        cc_ev_r[ch] <= ev_nxt;
      end
    end

    assign cap_val_o[ch*GPT_CNT_W +: GPT_CNT_W] = cap_r;
    assign ch_out_o[ch]                         = out_r;
  end

  // DMA request and trigger out; a new event beats a same-cycle ack
  always_comb begin
    dma_nxt = dma_r;
    if (dma_ack_i) dma_nxt = 1'b0;
    if (HAS_DMA && dma_en_i && (upd_r || (|cc_ev_r))) dma_nxt = 1'b1;
    tro_nxt = (trig_out_sel_i == GPT_TRO_CC0) ? cc_ev_r[0] : upd_nxt;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dma_r <= 1'b0;
      tro_r <= 1'b0;
    end else begin
      dma_r <= dma_nxt;
      tro_r <= tro_nxt;
    end
  end

  assign cnt_o      = cnt_r;
  assign dir_down_o = down_r;
  assign running_o  = run_r;
  assign update_o   = upd_r;
  assign trig_out_o = tro_r;
  assign cc_evt_o   = cc_ev_r;
  assign dma_req_o  = dma_r;

endmodule // gpt_timer

// File: verif/gpt_timer_sva.sv
`timescale 1ns/1ps
module gpt_timer_sva
  import gpt_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        cnt_en_i,
  input wire logic        dir_down_i,
  input wire logic        center_i,
  input wire logic        one_pulse_i,
  input wire logic [1:0]  clk_sel_i,
  input wire logic [15:0] psc_i,
  input wire logic [15:0] reload_i,
  input wire logic        dbg_halt_i,
  input wire logic        dbg_freeze_i,
  input wire logic [1:0]  slave_mode_i,
  input wire logic        trig_out_sel_i,
  input wire logic        hall_mode_i,
  input wire logic        dma_en_i,
  input wire logic        dma_ack_i,
  input wire logic [15:0] cnt_o,
  input wire logic        running_o,
  input wire logic        update_o,
  input wire logic        trig_out_o,
  input wire logic        dma_req_o
);
  logic [15:0] cnt_q_r;
  logic [15:0] cnt_q_nxt;
  logic [2:0]  gap_r;
  logic [2:0]  gap_nxt;
  logic        base_w;
  logic        slow_w;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Internal clock counting with nothing else able to move the counter
  assign base_w = running_o && cnt_en_i && clk_sel_i == GPT_CKS_INT && !center_i &&
                  slave_mode_i == GPT_SLV_OFF && !hall_mode_i && !(dbg_halt_i && dbg_freeze_i);
  assign slow_w = base_w && !dir_down_i && psc_i == 16'h0003;

  // Cycles since the last step; zero means no trusted reference yet
  always_comb begin
    cnt_q_nxt = cnt_o;
    gap_nxt   = (gap_r == 3'h7) ? gap_r : gap_r + 3'h1;
    if (cnt_o != cnt_q_r) gap_nxt = 3'h1;
    else if (gap_r == 3'h0) gap_nxt = 3'h0;
    if (!slow_w) gap_nxt = 3'h0;
  end

  // Registers of the step spacing helper
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q_r <= 16'h0000;
      gap_r   <= 3'h0;
    end else begin
      cnt_q_r <= cnt_q_nxt;
      gap_r   <= gap_nxt;
    end
  end

  sequence s_up_top;
    base_w && !dir_down_i && psc_i == 16'h0000 && cnt_o == reload_i;
  endsequence
  sequence s_frozen;
    (dbg_halt_i && dbg_freeze_i && slave_mode_i == GPT_SLV_OFF)[*2];
  endsequence

  a_up_wrap: assert property (s_up_top |=> cnt_o == 16'h0000 && update_o)
    else $error("up wrap missed");
  a_up_step: assert property (base_w && !dir_down_i && psc_i == 16'h0000 &&
    cnt_o < reload_i |=> cnt_o == $past(cnt_o) + 16'h0001) else $error("up step wrong");
  a_dn_wrap: assert property (base_w && dir_down_i && psc_i == 16'h0000 &&
    cnt_o == 16'h0000 |=> cnt_o == reload_i && update_o) else $error("down wrap missed");
  a_frz_hold: assert property (s_frozen |=> $stable(cnt_o))
    else $error("frozen counter moved");
  a_psc_gap: assert property (slow_w && gap_r != 3'h0 |->
    (cnt_o != cnt_q_r) == (gap_r == 3'h4)) else $error("prescaler spacing wrong");
  a_one_stop: assert property (one_pulse_i && update_o |=> !running_o)
    else $error("one pulse kept running");
  a_dma_set: assert property (dma_en_i && update_o |=> dma_req_o)
    else $error("dma request not raised");
  a_dma_keep: assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
    else $error("dma request dropped");
  a_trig_upd: assert property (!trig_out_sel_i && !$past(trig_out_sel_i) |->
    trig_out_o == update_o) else $error("trigger out differs from update");
endmodule // gpt_timer_sva

bind gpt_timer gpt_timer_sva u_sva (
  .clk_i, .rstn_i, .cnt_en_i, .dir_down_i, .center_i, .one_pulse_i, .clk_sel_i, .psc_i,
  .reload_i, .dbg_halt_i, .dbg_freeze_i, .slave_mode_i, .trig_out_sel_i, .hall_mode_i,
  .dma_en_i, .dma_ack_i, .cnt_o, .running_o, .update_o, .trig_out_o, .dma_req_o
);

// File: verif/gpt_ext_model.sv
`timescale 1ns/1ps
module gpt_ext_model (
  input  wire logic       clk_i,
  output logic            lse_clk_o,
  output logic      [3:0] cap_pin_o,
  output logic      [2:0] hall_o
);
  logic [1:0] ph_r;

  // Crystal runs free and unrelated to clk_i
  initial lse_clk_o = 1'b0;
  always #15259 lse_clk_o = ~lse_clk_o;

  initial begin
    ph_r      = 2'h0;
    cap_pin_o = 4'h0;
    hall_o    = 3'h0;
  end

  // One encoder edge, held long enough to pass the input synchroniser
  task automatic step(input logic up);
    ph_r = up ? ph_r + 2'h1 : ph_r - 2'h1;
    @(posedge clk_i);
    #1;
    cap_pin_o[1:0] = {ph_r[1], ph_r[1] ^ ph_r[0]};
    repeat (8) @(posedge clk_i);
    // Return off the edge so the caller never samples a launching edge
    #1;
  endtask

  // One hall sensor changes level; the caller watches the reaction
  task automatic hall_flip(input int s);
    @(posedge clk_i);
    #1;
    hall_o[s] = ~hall_o[s];
  endtask

  // Capture strobe on one channel pin
  task automatic cap_pulse(input int ch);
    @(posedge clk_i);
    #1;
    cap_pin_o[ch] = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    cap_pin_o[ch] = 1'b0;
  endtask
endmodule // gpt_ext_model

// File: verif/gpt_timer_tb_top.sv
`timescale 1ns/1ps
module gpt_timer_tb_top
  import gpt_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cnt_en_i, dir_down_i, center_i, one_pulse_i, dbg_halt_i, dbg_freeze_i;
  logic        trig_in_i, dma_en_i, dma_ack_i, lse_clk_i, dir_down_o, running_o;
  logic        update_o, trig_out_o, dma_req_o;
  logic        hall_mode_i = 1'b0;
  logic        trig_out_sel_i = GPT_TRO_UPDATE;
  logic [1:0]  clk_sel_i, slave_mode_i;
  logic [15:0] psc_i, reload_i, cnt_o, hi, n;
  logic [7:0]  ch_mode_i;
  logic [63:0] ccr_i, cap_val_o;
  logic [3:0]  cap_pin_i, ch_out_o, cc_evt_o;
  logic [2:0]  hall_i;
  logic [15:0] exp_q[$];
  int          errors = 0;
  int          total_checks = 0;
  int          seed = 32'h3D32;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  gpt_ext_model u_ext (
    .clk_i     (clk_i),
    .lse_clk_o (lse_clk_i),
    .cap_pin_o (cap_pin_i),
    .hall_o    (hall_i)
  );

  gpt_timer u_dut (
    .clk_i, .rstn_i, .cnt_en_i, .dir_down_i, .center_i, .one_pulse_i, .clk_sel_i, .psc_i,
    .reload_i, .dbg_halt_i, .dbg_freeze_i, .lse_clk_i, .trig_in_i, .slave_mode_i,
    .trig_out_sel_i, .hall_mode_i, .hall_i, .cap_pin_i, .ch_mode_i, .ccr_i, .dma_en_i,
    .dma_ack_i, .cnt_o, .dir_down_o, .running_o, .update_o, .trig_out_o, .ch_out_o,
    .cc_evt_o, .cap_val_o, .dma_req_o
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_q(input int lim);
    int i;
    for (i = 0; i < lim && exp_q.size() != 0; i++) tick(1);
    if (exp_q.size() != 0) begin
      errors++;
      give_verdict();
    end
  endtask

  // Peer timer trigger restarts the counter (zero counting up, reload_i counting down), which also reports an update
  task automatic zero(input logic [15:0] v);
    exp_q.push_back(v);
    slave_mode_i = GPT_SLV_RESET;
    trig_in_i = 1'b1;
    tick(1);
    trig_in_i = 1'b0;
    slave_mode_i = GPT_SLV_OFF;
    wait_q(20);
  endtask

  task automatic run2(input logic [15:0] v1, input logic [15:0] v2, input int lim);
    exp_q.push_back(v1);
    exp_q.push_back(v2);
    cnt_en_i = 1'b1;
    wait_q(lim);
    cnt_en_i = 1'b0;
  endtask

  // Every update pulse takes the oldest expected counter value
  always @(negedge clk_i) begin
    if (update_o === 1'b1) begin
      check(cnt_o, exp_q.size() != 0 ? exp_q.pop_front() : 16'hBEEF);
    end
  end

  initial begin
    {cnt_en_i, dir_down_i, center_i, one_pulse_i, dbg_halt_i, dbg_freeze_i} = 6'h00;
    {trig_in_i, dma_en_i, dma_ack_i} = 3'h0;
    {clk_sel_i, slave_mode_i, psc_i} = {GPT_CKS_INT, GPT_SLV_OFF, 16'h0000};
    reload_i  = 16'h0005;
    ch_mode_i = {GPT_CHM_PULSE, GPT_CHM_CAPTURE, GPT_CHM_PWM, GPT_CHM_TOGGLE};
    ccr_i     = {16'h0002, 16'h0000, 16'h0003, 16'h0001};
    tick(20);
    rstn_i = 1'b1;
    tick(2);
    // Up count with PWM on channel 1 and DMA on update
    dma_en_i = 1'b1;
    zero(16'h0000);
    repeat (3) exp_q.push_back(16'h0000);
    cnt_en_i = 1'b1;
    tick(3);
    hi = 16'h0000;
    repeat (12) begin
      if (ch_out_o[1] === 1'b1) hi++;
      tick(1);
    end
    check(hi, 16'h0006);
    wait_q(40);
    cnt_en_i = 1'b0;
    check({15'h0, dma_req_o}, 16'h0001);
    dma_en_i = 1'b0;
    dma_ack_i = 1'b1;
    tick(1);
    dma_ack_i = 1'b0;
    tick(1);
    check({15'h0, dma_req_o}, 16'h0000);
    // Down count, then centre count
    dir_down_i = 1'b1;
    reload_i = 16'h0004;
    zero(16'h0004);
    run2(16'h0004, 16'h0004, 40);
    dir_down_i = 1'b0;
    reload_i = 16'h0003;
    zero(16'h0000);
    center_i = 1'b1;
    // Direction is still down from the last run, so the first turn is at zero
    run2(16'h0001, 16'h0002, 40);
    check({15'h0, dir_down_o}, 16'h0001);
    center_i = 1'b0;
    // Divide by four; freeze needs both halt and freeze, so only ten cycles are lost
    psc_i = 16'h0003;
    reload_i = 16'h0002;
    zero(16'h0000);
    repeat (2) exp_q.push_back(16'h0000);
    cnt_en_i = 1'b1;
    for (n = 0; n < 200 && exp_q.size() == 2; n++) tick(1);
    dbg_halt_i = 1'b1;
    for (n = 0; n < 200 && exp_q.size() != 0; n++) begin
      dbg_freeze_i = (n < 16'd10);
      tick(1);
    end
    check(n, 16'd22);
    {cnt_en_i, dbg_halt_i, psc_i} = {2'b00, 16'h0000};
    // One pulse stops on its first update
    reload_i = 16'h0003;
    zero(16'h0000);
    one_pulse_i = 1'b1;
    exp_q.push_back(16'h0000);
    cnt_en_i = 1'b1;
    wait_q(40);
    tick(2);
    check({15'h0, running_o}, 16'h0000);
    {cnt_en_i, one_pulse_i} = 2'b00;
    // Quadrature steps forward, then back past zero
    reload_i = 16'h0009;
    zero(16'h0000);
    clk_sel_i = GPT_CKS_ENC;
    cnt_en_i = 1'b1;
    n = 16'h0001 + 16'($unsigned($random(seed)) % 7);
    repeat (n) u_ext.step(1'b1);
    check(cnt_o, n);
    exp_q.push_back(16'h0009);
    repeat (n + 16'h0001) u_ext.step(1'b0);
    check(cnt_o, 16'h0009);
    check({15'h0, dir_down_o}, 16'h0001);
    u_ext.cap_pulse(2);
    check(cap_val_o[47:32], 16'h0009);
    {cnt_en_i, clk_sel_i} = {1'b0, GPT_CKS_INT};
    // Peer trigger pulses as the count clock
    reload_i = 16'h00FF;
    zero(16'h0000);
    clk_sel_i = GPT_CKS_TRIG;
    cnt_en_i = 1'b1;
    tick(2);
    repeat (5) begin
      trig_in_i = 1'b1;
      tick(1);
      trig_in_i = 1'b0;
      tick(2);
    end
    check(cnt_o, 16'h0005);
    {cnt_en_i, clk_sel_i} = {1'b0, GPT_CKS_INT};
    // Gated by the peer: counts only while its trigger is high
    slave_mode_i = GPT_SLV_GATED;
    tick(1);
    cnt_en_i = 1'b1;
    tick(4);
    trig_in_i = 1'b1;
    tick(3);
    trig_in_i = 1'b0;
    tick(2);
    check(cnt_o, 16'h0008);
    // Start mode waits for the peer; stopping under the gate lets no step slip in
    cnt_en_i = 1'b0;
    tick(1);
    {cnt_en_i, slave_mode_i} = {1'b1, GPT_SLV_START};
    tick(3);
    check({15'h0, running_o}, 16'h0000);
    trig_in_i = 1'b1;
    tick(1);
    trig_in_i = 1'b0;
    tick(3);
    check(cnt_o, 16'h000B);
    {cnt_en_i, slave_mode_i} = {1'b0, GPT_SLV_GATED};
    tick(1);
    // Hall commutation captures on channel 0 and restarts the count
    {slave_mode_i, hall_mode_i, trig_out_sel_i} = {GPT_SLV_OFF, 1'b1, GPT_TRO_CC0};
    ch_mode_i[1:0] = GPT_CHM_CAPTURE;
    exp_q.push_back(16'h0000);
    u_ext.hall_flip(2);
    {hi, n} = 32'h0;
    repeat (8) begin
      tick(1);
      if (cc_evt_o[0] === 1'b1) hi++;
      if (trig_out_o === 1'b1) n++;
    end
    check(hi, 16'h0001);
    check(n, 16'h0001);
    check(cap_val_o[15:0], 16'h000B);
    wait_q(4);
    {hall_mode_i, trig_out_sel_i} = {1'b0, GPT_TRO_UPDATE};
    // Time base on the low-speed crystal
    reload_i = 16'h0001;
    zero(16'h0000);
    clk_sel_i = GPT_CKS_LSE;
    run2(16'h0000, 16'h0000, 30000);
    give_verdict();
  end
endmodule // gpt_timer_tb_top
